// ### hdl/sad_decoder.sv
// System address decoder: APB slave that routes each mapped bus address to a flash
// subarea, an SRAM bank, a peripheral slot or the core private region, holds
// the start-up configuration word and a small set of attribute registers.
// Assumes a single pclk domain; targets answer through tgt_ack/tgt_rdata.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "sad_consts.svh"

// Operation
// - Code region 0x00000000-0x0007FFFF goes to the non-volatile code targets.
// - Data region 0x20000000-0x20007FFF goes to the 32 KB SRAM.
// - Peripheral space and core private region are routed to their targets.
// - Addresses 0x0-0x3E7FF select the application flash area.
// - Addresses 0x3E800-0x3EFFF select the user data flash area.
// - Addresses 0x3F000-0x3FFFF select the boot program flash area.
// - 0x40000-0x403FF select configuration flash; the rest of code is unused.
// - The configuration word lives at 0x00040010 and sets start-up options.
// - Configuration bit 3 enables the manual reset pin, default off.
// - Bit 4 enables debug, bit 6 enables boot program, both default on.
// - Bit 7 low blocks programmer readout, high permits it, default high.
// - Configuration word is valid only when bits 31 to 28 equal 0101.
// - Addresses 0x20000000-0x20003FFF select the main-supply SRAM bank.
// - The two retained SRAM banks follow at 0x20004000 and 0x20007800.
// - Peripheral register address equals slot base plus register offset.
// - Control, analog, flash, timer and serial slots sit at their bases.
// - Synchronous serial, PWM, display, USB, network and radio slots follow.
// - Fixed-read bits return a constant untouched by reset.
// - Clear-on-read bits return their value and then clear.
// - Write-one-clear bits are readable; writing one clears, zero keeps.
// - Safe-mode bits take writes only in safe mode; readable variant always reads.
module sad_decoder (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      tgt_req,
   output sad_pkg::sad_target_t      tgt_sel,
   output logic [4:0]                tgt_slot,
   output logic [31:0]               tgt_offset,
   output logic                      tgt_write,
   output logic [31:0]               tgt_wdata,
   input  wire logic                 tgt_ack,
   input  wire logic [31:0]          tgt_rdata,
   input  wire logic [7:0]           evt_in,
   input  wire logic                 safe_mode,
   input  wire logic [31:0]          cfg_word_in,
   output logic [7:0]                safe_ctrl,
   output logic [7:0]                safe_key,
   output logic                      cfg_valid,
   output logic                      manual_reset_en,
   output logic                      debug_en,
   output logic                      boot_en,
   output logic                      readout_allowed
);

   localparam logic [31:0] SLOT_BASE [`SAD_SLOT_COUNT] = `SAD_SLOT_BASE_LIST;
   localparam logic [31:0] SLOT_SPAN [`SAD_SLOT_COUNT] = `SAD_SLOT_SPAN_LIST;

   localparam sad_pkg::sad_state_rec_t RESET_REC = '{
      st:         sad_pkg::SAD_ST_IDLE,
      tgt:        sad_pkg::SAD_TGT_NONE,
      mr_en:      `SAD_MR_EN_RESET,
      dbg_en:     `SAD_DBG_EN_RESET,
      boot_en:    `SAD_BOOT_EN_RESET,
      rd_allow:   `SAD_RD_ALLOW_RESET,
      default:    '0
   };

   sad_pkg::sad_state_rec_t  q;
   sad_pkg::sad_state_rec_t  next_q;
   logic [`SAD_SLOT_COUNT-1:0] slot_hit;
   sad_pkg::sad_target_t     dec_tgt;
   logic [4:0]               dec_slot;
   logic [31:0]              dec_offset;
   logic [31:0]              local_rdata;
   logic [7:0]               local_reg;

   // Each peripheral slot compares the address against its own window.
   genvar gi;
   generate
      for (gi = 0; gi < `SAD_SLOT_COUNT; gi++) begin : g_slot
         assign slot_hit[gi] = (paddr & ~SLOT_SPAN[gi]) == SLOT_BASE[gi];
      end
   endgenerate

   // Address decode of the request in its setup cycle.
   always_comb begin
      dec_tgt    = sad_pkg::SAD_TGT_NONE;
      dec_slot   = 5'h00;
      dec_offset = 32'h0000_0000;
      if (paddr <= `SAD_CODE_END) begin
         if (paddr <= `SAD_APP_FLASH_END) begin
            dec_tgt    = sad_pkg::SAD_TGT_APP_FLASH;
            dec_offset = paddr - `SAD_CODE_BASE;
         end else if (paddr <= `SAD_DATA_FLASH_END) begin
            dec_tgt    = sad_pkg::SAD_TGT_DATA_FLASH;
            dec_offset = paddr - `SAD_DATA_FLASH_BASE;
         end else if (paddr <= `SAD_BOOT_FLASH_END) begin
            dec_tgt    = sad_pkg::SAD_TGT_BOOT_FLASH;
            dec_offset = paddr - `SAD_BOOT_FLASH_BASE;
         end else if (paddr <= `SAD_INFO_FLASH_END) begin
            dec_tgt    = sad_pkg::SAD_TGT_INFO_FLASH;
            dec_offset = paddr - `SAD_INFO_FLASH_BASE;
         end
      end else if (paddr >= `SAD_SRAM_BASE && paddr <= `SAD_SRAM_END) begin
         if (paddr <= `SAD_SRAM16_END) begin
            dec_tgt    = sad_pkg::SAD_TGT_SRAM_MAIN;
            dec_offset = paddr - `SAD_SRAM_BASE;
         end else if (paddr <= `SAD_SRAM14_END) begin
            dec_tgt    = sad_pkg::SAD_TGT_SRAM_RET_LARGE;
            dec_offset = paddr - `SAD_SRAM14_BASE;
         end else begin
            dec_tgt    = sad_pkg::SAD_TGT_SRAM_RET_SMALL;
            dec_offset = paddr - `SAD_SRAM2_BASE;
         end
      end else if (paddr >= `SAD_PERIPH_BASE && paddr <= `SAD_PERIPH_END) begin
         if ((paddr & ~`SAD_LOCAL_SPAN) == `SAD_LOCAL_BASE) begin
            dec_tgt    = sad_pkg::SAD_TGT_LOCAL;
            dec_offset = paddr - `SAD_LOCAL_BASE;
         end else begin
            for (int i = 0; i < `SAD_SLOT_COUNT; i++) begin
               if (slot_hit[i]) begin
                  dec_tgt    = sad_pkg::SAD_TGT_PERIPH;
                  dec_slot   = 5'(i);
                  dec_offset = paddr - SLOT_BASE[i];
               end
            end
         end
      end else if (paddr >= `SAD_PPB_BASE && paddr <= `SAD_PPB_END) begin
         dec_tgt    = sad_pkg::SAD_TGT_CORE_PRIVATE;
         dec_offset = paddr - `SAD_PPB_BASE;
      end
   end

   assign local_reg = q.offset[7:0];

   // Read view of the local registers.
   always_comb begin
      local_rdata = 32'h0000_0000;
      case (local_reg)
         `SAD_REG_EVT_RZ:    local_rdata = {24'h00_0000, q.evt_rz};
         `SAD_REG_EVT_W1C:   local_rdata = {24'h00_0000, q.evt_w1c};
         `SAD_REG_SAFE_CTRL: local_rdata = {24'h00_0000, q.safe_ctrl};
         `SAD_REG_SAFE_KEY:  local_rdata = 32'h0000_0000;
         `SAD_REG_FIXED_ID:  local_rdata = `SAD_FIXED_ID_VALUE;
         `SAD_REG_CFG_COPY:  local_rdata = q.cfg_word;
         default:            local_rdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_q = q;
      case (q.st)
         sad_pkg::SAD_ST_IDLE: begin
            if (psel && !penable) begin
               next_q.tgt    = dec_tgt;
               next_q.slot   = dec_slot;
               next_q.offset = dec_offset;
               next_q.write  = pwrite;
               next_q.wdata  = pwdata;
               next_q.st     = sad_pkg::SAD_ST_ACCESS;
            end
         end
         sad_pkg::SAD_ST_ACCESS: begin
            if (q.tgt == sad_pkg::SAD_TGT_LOCAL || q.tgt == sad_pkg::SAD_TGT_NONE) begin
               next_q.prdata = 32'h0000_0000;
               if (q.tgt == sad_pkg::SAD_TGT_LOCAL && !q.write) begin
                  next_q.prdata = local_rdata;
               end
               next_q.pready = 1'b1;
               next_q.st     = sad_pkg::SAD_ST_DONE;
            end else begin
               next_q.tgt_req = 1'b1;
               next_q.st      = sad_pkg::SAD_ST_FORWARD;
            end
         end
         sad_pkg::SAD_ST_FORWARD: begin
            if (tgt_ack) begin
               next_q.tgt_req = 1'b0;
               next_q.prdata  = q.write ? 32'h0000_0000 : tgt_rdata;
               next_q.pready  = 1'b1;
               next_q.st      = sad_pkg::SAD_ST_DONE;
            end
         end
         sad_pkg::SAD_ST_DONE: begin
            // Side effects land only at the edge that completes the transfer.
            if (psel && penable) begin
               next_q.pready = 1'b0;
               next_q.st     = sad_pkg::SAD_ST_IDLE;
               if (q.tgt == sad_pkg::SAD_TGT_LOCAL) begin
                  if (!q.write && local_reg == `SAD_REG_EVT_RZ) begin
                     // Only bits that were returned are cleared.
                     next_q.evt_rz = q.evt_rz & ~q.prdata[7:0];
                  end
                  if (q.write && local_reg == `SAD_REG_EVT_W1C) begin
                     next_q.evt_w1c = q.evt_w1c & ~q.wdata[7:0];
                  end
                  if (q.write && safe_mode && local_reg == `SAD_REG_SAFE_CTRL) begin
                     next_q.safe_ctrl = q.wdata[7:0];
                  end
                  if (q.write && safe_mode && local_reg == `SAD_REG_SAFE_KEY) begin
                     next_q.safe_key = q.wdata[7:0];
                  end
               end
            end
         end
         default: begin
            next_q = RESET_REC;
         end
      endcase

      // A new event wins over a clear in the same cycle.
      next_q.evt_rz  = next_q.evt_rz | evt_in;
      next_q.evt_w1c = next_q.evt_w1c | evt_in;

      // The configuration word is caught once, on the first edge after reset.
      if (!q.cfg_loaded) begin
         next_q.cfg_loaded = 1'b1;
         next_q.cfg_word   = cfg_word_in;
         next_q.cfg_valid  = cfg_word_in[`SAD_CFG_SIG_MSB:`SAD_CFG_SIG_LSB]
                             == `SAD_CFG_SIG_VALUE;
         if (next_q.cfg_valid) begin
            next_q.mr_en    = cfg_word_in[`SAD_CFG_MR_EN_BIT];
            next_q.dbg_en   = cfg_word_in[`SAD_CFG_DBG_EN_BIT];
            next_q.boot_en  = cfg_word_in[`SAD_CFG_BOOT_EN_BIT];
            next_q.rd_allow = cfg_word_in[`SAD_CFG_RD_ALLOW_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET_REC;
      end else begin
         q <= next_q;
      end
   end

   assign pready          = q.pready;
   assign prdata          = q.prdata;
   assign tgt_req         = q.tgt_req;
   assign tgt_sel         = q.tgt;
   assign tgt_slot        = q.slot;
   assign tgt_offset      = q.offset;
   assign tgt_write       = q.write;
   assign tgt_wdata       = q.wdata;
   assign safe_ctrl       = q.safe_ctrl;
   assign safe_key        = q.safe_key;
   assign cfg_valid       = q.cfg_valid;
   assign manual_reset_en = q.mr_en;
   assign debug_en        = q.dbg_en;
   assign boot_en         = q.boot_en;
   assign readout_allowed = q.rd_allow;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable && q.st == sad_pkg::SAD_ST_IDLE;
   endsequence

   sequence s_done;
      psel && penable && q.pready;
   endsequence

   chk_code_region: assert property (s_setup and (paddr <= `SAD_CODE_END) |=>
      q.tgt inside {sad_pkg::SAD_TGT_APP_FLASH, sad_pkg::SAD_TGT_DATA_FLASH,
                    sad_pkg::SAD_TGT_BOOT_FLASH, sad_pkg::SAD_TGT_INFO_FLASH,
                    sad_pkg::SAD_TGT_NONE})
      else $error("code address routed outside code targets");

   chk_app_flash_sel: assert property (s_setup and (paddr == `SAD_APP_FLASH_END) |=>
      q.tgt == sad_pkg::SAD_TGT_APP_FLASH && q.offset == `SAD_APP_FLASH_END)
      else $error("last application flash word misrouted");

   chk_data_flash_sel: assert property (s_setup and (paddr == `SAD_DATA_FLASH_BASE) |=>
      q.tgt == sad_pkg::SAD_TGT_DATA_FLASH && q.offset == 32'h0000_0000)
      else $error("data flash base misrouted");

   chk_boot_flash_sel: assert property (s_setup and (paddr == `SAD_BOOT_FLASH_BASE) |=>
      q.tgt == sad_pkg::SAD_TGT_BOOT_FLASH)
      else $error("boot flash base misrouted");

   chk_code_unused: assert property (s_setup and (paddr > `SAD_INFO_FLASH_END)
      and (paddr <= `SAD_CODE_END) |=> q.tgt == sad_pkg::SAD_TGT_NONE)
      else $error("unused code address selected a target");

   chk_sram_banks: assert property (s_setup and (paddr == `SAD_SRAM14_BASE) |=>
      q.tgt == sad_pkg::SAD_TGT_SRAM_RET_LARGE)
      else $error("retained bank base misrouted");

   chk_sram_main: assert property (s_setup and (paddr == `SAD_SRAM16_END) |=>
      q.tgt == sad_pkg::SAD_TGT_SRAM_MAIN)
      else $error("main bank top misrouted");

   chk_periph_offset: assert property (s_setup and slot_hit[7] |=>
      q.tgt == sad_pkg::SAD_TGT_PERIPH && q.slot == 5'h07
      && q.offset == $past(paddr) - SLOT_BASE[7])
      else $error("peripheral offset not address minus base");

   chk_reserved_read: assert property (s_setup and (paddr == `SAD_PERIPH_END)
      and !pwrite |=> ##1 q.pready && q.prdata == 32'h0000_0000 && !q.tgt_req)
      else $error("reserved read not answered with zero");

   chk_local_latency: assert property (s_setup and (dec_tgt == sad_pkg::SAD_TGT_LOCAL) |=>
      !q.pready ##1 q.pready)
      else $error("local register answer not in second access cycle");

   chk_clear_on_read: assert property (s_done and (q.tgt == sad_pkg::SAD_TGT_LOCAL)
      and !q.write and (local_reg == `SAD_REG_EVT_RZ) |=>
      q.evt_rz == (($past(q.evt_rz) & ~$past(q.prdata[7:0])) | $past(evt_in)))
      else $error("clear-on-read bits not cleared");

   chk_safe_guard: assert property (s_done and q.write and !safe_mode
      and (q.tgt == sad_pkg::SAD_TGT_LOCAL) |=> $stable(q.safe_ctrl) && $stable(q.safe_key))
      else $error("protected register written outside safe mode");

   chk_cfg_invalid: assert property (!q.cfg_loaded and
      (cfg_word_in[`SAD_CFG_SIG_MSB:`SAD_CFG_SIG_LSB] != `SAD_CFG_SIG_VALUE) |=>
      !q.cfg_valid && !q.mr_en && q.dbg_en && q.boot_en && q.rd_allow)
      else $error("invalid configuration word not ignored");

endmodule

// ### pkg/sad_consts.svh
// Constants of the system address decoder: region limits, slot table, local
// register offsets, configuration word fields and reset values.
// Assumes a 32-bit byte-addressed system bus reached over APB.
`ifndef SAD_CONSTS_SVH
`define SAD_CONSTS_SVH

`define SAD_CODE_BASE        32'h0000_0000
`define SAD_CODE_END         32'h0007_ffff
`define SAD_APP_FLASH_END    32'h0003_e7ff
`define SAD_DATA_FLASH_BASE  32'h0003_e800
`define SAD_DATA_FLASH_END   32'h0003_efff
`define SAD_BOOT_FLASH_BASE  32'h0003_f000
`define SAD_BOOT_FLASH_END   32'h0003_ffff
`define SAD_INFO_FLASH_BASE  32'h0004_0000
`define SAD_INFO_FLASH_END   32'h0004_03ff
`define SAD_CFG_WORD_ADDR    32'h0004_0010

`define SAD_SRAM_BASE        32'h2000_0000
`define SAD_SRAM_END         32'h2000_7fff
`define SAD_SRAM16_END       32'h2000_3fff
`define SAD_SRAM14_BASE      32'h2000_4000
`define SAD_SRAM14_END       32'h2000_77ff
`define SAD_SRAM2_BASE       32'h2000_7800

`define SAD_PERIPH_BASE      32'h4000_0000
`define SAD_PERIPH_END       32'h4000_ffff
`define SAD_PPB_BASE         32'he000_0000
`define SAD_PPB_END          32'he000_ffff

`define SAD_SLOT_COUNT       20
`define SAD_SLOT_BASE_LIST   '{32'h4000_1000, 32'h4000_1400, 32'h4000_1800, 32'h4000_2000, \
                               32'h4000_2400, 32'h4000_2800, 32'h4000_2c00, 32'h4000_3000, \
                               32'h4000_3400, 32'h4000_3800, 32'h4000_3c00, 32'h4000_4000, \
                               32'h4000_4400, 32'h4000_5000, 32'h4000_6000, 32'h4000_6400, \
                               32'h4000_8000, 32'h4000_9000, 32'h4000_c000, 32'h4000_d000}
`define SAD_SLOT_SPAN_LIST   '{32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, \
                               32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, \
                               32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, \
                               32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, \
                               32'h0000_0fff, 32'h0000_0fff, 32'h0000_0fff, 32'h0000_0fff}

`define SAD_LOCAL_BASE       32'h4000_f000
`define SAD_LOCAL_SPAN       32'h0000_00ff
`define SAD_REG_EVT_RZ       8'h00
`define SAD_REG_EVT_W1C      8'h04
`define SAD_REG_SAFE_CTRL    8'h08
`define SAD_REG_SAFE_KEY     8'h0c
`define SAD_REG_FIXED_ID     8'h10
`define SAD_REG_CFG_COPY     8'h14

`define SAD_FIXED_ID_VALUE   32'h0000_5a01
`define SAD_CFG_MR_EN_BIT    3
`define SAD_CFG_DBG_EN_BIT   4
`define SAD_CFG_BOOT_EN_BIT  6
`define SAD_CFG_RD_ALLOW_BIT 7
`define SAD_CFG_SIG_MSB      31
`define SAD_CFG_SIG_LSB      28
`define SAD_CFG_SIG_VALUE    4'h5
`define SAD_MR_EN_RESET      1'b0
`define SAD_DBG_EN_RESET     1'b1
`define SAD_BOOT_EN_RESET    1'b1
`define SAD_RD_ALLOW_RESET   1'b1

`endif

// ### pkg/sad_pkg.sv
// Types of the system address decoder: targets, control states, state record.
// Assumes sad_consts.svh supplies all numeric constants.
package sad_pkg;

   typedef enum logic [3:0] {
      SAD_TGT_NONE,
      SAD_TGT_APP_FLASH,
      SAD_TGT_DATA_FLASH,
      SAD_TGT_BOOT_FLASH,
      SAD_TGT_INFO_FLASH,
      SAD_TGT_SRAM_MAIN,
      SAD_TGT_SRAM_RET_LARGE,
      SAD_TGT_SRAM_RET_SMALL,
      SAD_TGT_PERIPH,
      SAD_TGT_CORE_PRIVATE,
      SAD_TGT_LOCAL
   } sad_target_t;

   typedef enum logic [1:0] {
      SAD_ST_IDLE,
      SAD_ST_ACCESS,
      SAD_ST_FORWARD,
      SAD_ST_DONE
   } sad_state_t;

   typedef struct packed {
      sad_state_t  st;
      sad_target_t tgt;
      logic [4:0]  slot;
      logic [31:0] offset;
      logic        write;
      logic [31:0] wdata;
      logic        pready;
      logic [31:0] prdata;
      logic        tgt_req;
      logic [7:0]  evt_rz;
      logic [7:0]  evt_w1c;
      logic [7:0]  safe_ctrl;
      logic [7:0]  safe_key;
      logic        cfg_loaded;
      logic [31:0] cfg_word;
      logic        cfg_valid;
      logic        mr_en;
      logic        dbg_en;
      logic        boot_en;
      logic        rd_allow;
   } sad_state_rec_t;

endpackage

// ### tb/sad_tgt_model.sv
// Target-side model: answers every forwarded request after lat extra cycles.
// Assumes tgt_req stays high, with its qualifiers, until tgt_ack is sampled.
`timescale 1ns/1ns
module sad_tgt_model (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 tgt_req,
   input  wire sad_pkg::sad_target_t tgt_sel,
   input  wire logic [31:0]          tgt_offset,
   input  wire logic [1:0]           lat,
   output logic                      tgt_ack,
   output logic [31:0]               tgt_rdata
);
   logic [2:0] cnt;
   // Outside an answer the data bus toggles so stale data never looks valid.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= 3'h0;
         tgt_ack   <= 1'b0;
         tgt_rdata <= 32'h0;
      end else begin
         tgt_ack   <= 1'b0;
         tgt_rdata <= ~tgt_rdata;
         if (tgt_req && !tgt_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt == {1'b0, lat}) begin
               tgt_ack   <= 1'b1;
               tgt_rdata <= {tgt_sel, tgt_offset[27:0]};
               cnt       <= 3'h0;
            end
         end
      end
   end
endmodule

// ### tb/sad_decoder_tb.sv
// Testbench of the address decoder: region walk, configuration word, attribute registers.
// Assumes sad_tgt_model answers forwarded transfers; APB master waits with a bound.
`timescale 1ns/1ns
`include "sad_consts.svh"
module sad_decoder_tb;
   localparam logic [31:0] L = `SAD_LOCAL_BASE;
   logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic                 pwrite = 1'b0, safe_mode = 1'b0, saw_req;
   logic [31:0]          paddr = '0, pwdata = '0, cfg_word_in = '0, prdata, tgt_offset;
   logic [31:0]          tgt_wdata, tgt_rdata, r, seed = 32'h5bb6dab1;
   logic [7:0]           evt_in = '0, safe_ctrl, safe_key, m, v;
   logic [4:0]           tgt_slot;
   logic [1:0]           lat = '0;
   logic                 pready, tgt_req, tgt_write, tgt_ack;
   logic                 cfg_valid, manual_reset_en, debug_en, boot_en, readout_allowed;
   sad_pkg::sad_target_t tgt_sel, rt[$];
   logic [31:0]          rb[$], re[$];
   logic [31:0]          bases [20] = `SAD_SLOT_BASE_LIST;
   logic [31:0]          spans [20] = `SAD_SLOT_SPAN_LIST;
   int                   rs[$], fails = 0, num_checks = 0;

   always #20 pclk = ~pclk;

   sad_decoder i_sad_decoder (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .tgt_req(tgt_req),
      .tgt_sel(tgt_sel), .tgt_slot(tgt_slot), .tgt_offset(tgt_offset),
      .tgt_write(tgt_write), .tgt_wdata(tgt_wdata), .tgt_ack(tgt_ack),
      .tgt_rdata(tgt_rdata), .evt_in(evt_in), .safe_mode(safe_mode),
      .cfg_word_in(cfg_word_in), .safe_ctrl(safe_ctrl), .safe_key(safe_key),
      .cfg_valid(cfg_valid), .manual_reset_en(manual_reset_en), .debug_en(debug_en),
      .boot_en(boot_en), .readout_allowed(readout_allowed));

   sad_tgt_model i_sad_tgt_model (
      .pclk(pclk), .presetn(presetn), .tgt_req(tgt_req), .tgt_sel(tgt_sel),
      .tgt_offset(tgt_offset), .lat(lat), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One idle cycle precedes every setup, so no signal is driven twice in a step.
   task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, saw_req} <= {1'b1, 1'b0, w, a, d, 1'b0};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         saw_req |= tgt_req;
         n++;
      end while (pready !== 1'b1 && n < 60);
      if (pready !== 1'b1) begin
         fails++;
         tally_and_finish();
      end else begin
         q = prdata;
         {psel, penable} <= 2'b00;
      end
   endtask

   task automatic add(input logic [31:0] b, e, input sad_pkg::sad_target_t t, input int s);
      rb.push_back(b);
      re.push_back(e);
      rt.push_back(t);
      rs.push_back(s);
   endtask

   task automatic route(input int i, input logic [31:0] a);
      logic        w;
      logic        fwd;
      logic [31:0] off;
      w   = seed[5];
      fwd = rt[i] != sad_pkg::SAD_TGT_NONE;
      off = a - rb[i];
      apb(w, a, seed, r);
      chk(tgt_sel, rt[i]);
      chk(tgt_slot, rs[i]);
      chk(saw_req, fwd);
      chk(r, (fwd && !w) ? {rt[i], off[27:0]} : 32'h0);
      if (fwd) begin
         chk(tgt_offset, off);
         chk(tgt_write, w);
         if (w) chk(tgt_wdata, seed);
      end
      seed = lfsr(seed);
      lat <= seed[1:0];
   endtask

   task automatic rst(input logic [31:0] cw);
      logic ok;
      ok = cw[31:28] == 4'h5;
      presetn <= 1'b0;
      cfg_word_in <= cw;
      repeat (6) @(posedge pclk);
      chk({debug_en, boot_en, readout_allowed, manual_reset_en, cfg_valid}, 5'h1c);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(cfg_valid, ok);
      chk(manual_reset_en, ok & cw[3]);
      chk({debug_en, boot_en}, ok ? {cw[4], cw[6]} : 2'b11);
      chk(readout_allowed, !ok | cw[7]);
      apb(1'b1, L + `SAD_REG_CFG_COPY, ~cw, r);
      apb(1'b0, L + `SAD_REG_CFG_COPY, 32'h0, r);
      chk(r, cw);
      apb(1'b0, L + `SAD_REG_FIXED_ID, 32'h0, r);
      chk(r, `SAD_FIXED_ID_VALUE);
      apb(1'b0, L + `SAD_REG_EVT_RZ, 32'h0, r);
      chk(r, 32'h0);
   endtask

   initial begin
      rst({4'h5, seed[27:0]});
      add(`SAD_CODE_BASE, `SAD_APP_FLASH_END, sad_pkg::SAD_TGT_APP_FLASH, 0);
      add(`SAD_DATA_FLASH_BASE, `SAD_DATA_FLASH_END, sad_pkg::SAD_TGT_DATA_FLASH, 0);
      add(`SAD_BOOT_FLASH_BASE, `SAD_BOOT_FLASH_END, sad_pkg::SAD_TGT_BOOT_FLASH, 0);
      add(`SAD_INFO_FLASH_BASE, `SAD_INFO_FLASH_END, sad_pkg::SAD_TGT_INFO_FLASH, 0);
      add(`SAD_SRAM_BASE, `SAD_SRAM16_END, sad_pkg::SAD_TGT_SRAM_MAIN, 0);
      add(`SAD_SRAM14_BASE, `SAD_SRAM14_END, sad_pkg::SAD_TGT_SRAM_RET_LARGE, 0);
      add(`SAD_SRAM2_BASE, `SAD_SRAM_END, sad_pkg::SAD_TGT_SRAM_RET_SMALL, 0);
      add(`SAD_PPB_BASE, `SAD_PPB_END, sad_pkg::SAD_TGT_CORE_PRIVATE, 0);
      add(32'h0004_0400, 32'h1fff_ffff, sad_pkg::SAD_TGT_NONE, 0);
      add(32'h2000_8000, 32'h3fff_ffff, sad_pkg::SAD_TGT_NONE, 0);
      add(32'h4001_0000, 32'hdfff_ffff, sad_pkg::SAD_TGT_NONE, 0);
      add(32'h4000_0000, 32'h4000_0fff, sad_pkg::SAD_TGT_NONE, 0);
      add(32'h4000_f100, 32'h4000_ffff, sad_pkg::SAD_TGT_NONE, 0);
      add(32'he001_0000, 32'hffff_ffff, sad_pkg::SAD_TGT_NONE, 0);
      for (int i = 0; i < 20; i++) add(bases[i], bases[i] + spans[i], sad_pkg::SAD_TGT_PERIPH, i);
      foreach (rb[i]) begin
         route(i, rb[i]);
         route(i, re[i] & ~32'h3);
         route(i, rb[i] + ((seed % (re[i] - rb[i] + 32'h1)) & ~32'h3));
      end
      route(3, `SAD_CFG_WORD_ADDR);
      m = seed[7:0] | 8'h81;
      v = seed[15:8] | 8'h10;
      evt_in <= m;
      @(posedge pclk);
      evt_in <= 8'h0;
      apb(1'b1, L + `SAD_REG_EVT_RZ, 32'hff, r);
      apb(1'b0, L + `SAD_REG_EVT_RZ, 32'h0, r);
      chk(r, m);
      apb(1'b0, L + `SAD_REG_EVT_RZ, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b1, L + `SAD_REG_EVT_W1C, 32'h01, r);
      apb(1'b0, L + `SAD_REG_EVT_W1C, 32'h0, r);
      chk(r, m & 8'hfe);
      apb(1'b1, L + `SAD_REG_SAFE_CTRL, v, r);
      apb(1'b0, L + `SAD_REG_SAFE_CTRL, 32'h0, r);
      chk(r, 32'h0);
      chk(safe_ctrl, 32'h0);
      safe_mode <= 1'b1;
      apb(1'b1, L + `SAD_REG_SAFE_CTRL, v, r);
      apb(1'b1, L + `SAD_REG_SAFE_KEY, ~v, r);
      apb(1'b0, L + `SAD_REG_SAFE_KEY, 32'h0, r);
      chk(r, 32'h0);
      chk(safe_key, {24'h0, ~v});
      safe_mode <= 1'b0;
      apb(1'b1, L + `SAD_REG_SAFE_KEY, v, r);
      apb(1'b0, L + `SAD_REG_SAFE_CTRL, 32'h0, r);
      chk(r, {24'h0, v});
      chk(safe_ctrl, {24'h0, v});
      chk(safe_key, {24'h0, ~v});
      apb(1'b1, L + 32'h40, 32'hffff_ffff, r);
      apb(1'b0, L + 32'h40, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b0, `SAD_PERIPH_END, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b1, L + `SAD_REG_FIXED_ID, 32'hffff_ffff, r);
      rst({4'h4, seed[27:0]});
      rst(32'h5000_0000);
      rst(32'h5fff_ffff);
      tally_and_finish();
   end
endmodule
